// *** design/usart_slave_params.svh ***
// Register map, field positions, reset values and counts for the clocked slave serial port
`ifndef USART_SLAVE_PARAMS_SVH
`define USART_SLAVE_PARAMS_SVH

// Bus geometry
`define APB_ADDR_W          12
`define APB_DATA_W          32

// Byte addresses, one aligned word each
`define OFS_RX_CONTROL      12'h000
`define OFS_TX_HOLDING      12'h004
`define OFS_TX_CONTROL      12'h008
`define OFS_BAUD_DIVISOR    12'h00C
`define OFS_RX_FIFO         12'h010
`define OFS_IRQ_CONTROL     12'h014

// Transmit control/status fields
`define TXC_CLOCK_SOURCE    7
`define TXC_NINTH_ENABLE    6
`define TXC_TRANSMITTER_ON  5
`define TXC_SYNC_MODE       4
`define TXC_HIGH_SPEED      2
`define TXC_SHIFT_EMPTY     1
`define TXC_NINTH_VALUE     0
`define TXC_WRITE_MASK      8'hF5
`define TXC_RESET           8'h02

// Receive control/status fields
`define RXC_PORT_ON         7
`define RXC_NINTH_ENABLE    6
`define RXC_SINGLE_ENABLE   5
`define RXC_CONT_ENABLE     4
`define RXC_FRAMING_ERROR   2
`define RXC_OVERRUN         1
`define RXC_NINTH_VALUE     0
`define RXC_WRITE_MASK      8'hF0
`define RXC_RESET           8'h00

// Interrupt control fields
`define IRQ_TX_ENABLE       0
`define IRQ_RX_ENABLE       1
`define IRQ_TX_FLAG         4
`define IRQ_RX_FLAG         5

// Other reset values and word lengths
`define TXH_RESET           8'h00
`define BAUD_RESET          8'h00
`define WORD_BITS_8         4'h8
`define WORD_BITS_9         4'h9

`endif

// *** design/usart_slave_pkg.sv ***
// Types shared by the clocked slave serial port
package usart_slave_pkg;

    // One received word with its ninth bit
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } rx_entry_s;

    // Transmit shifter progress
    typedef enum {
        TX_IDLE,
        TX_SHIFT,
        TX_LAST
    } tx_state_e;

endpackage

// *** design/usart_sync_slave.sv ***
// Clocked slave serial port: APB registers, transmit shifter, receive shifter and FIFO
`timescale 1ns/1ps
`default_nettype none
`include "usart_slave_params.svh"

// Operation
// [RQ1] Shift clock comes from the far master; device never generates it.
// [RQ2] Clearing clock source select in clocked mode selects slave operation.
// [RQ3] Shifting continues while the core is asleep.
// [RQ4] Holding word moves into an empty shift register at once.
// [RQ5] Second word waits in holding buffer; buffer empty flag stays clear.
// [RQ6] After first word ends, waiting word moves in, then empty flag sets.
// [RQ7] Empty flag with transmit enable raises a wake interrupt.
// [RQ8] Slave transfers behave like master transfers apart from clock and sleep.
// [RQ9] Software sets up slave transmit with receive enables cleared.
// [RQ10] Ninth transmit bit is loaded before the data byte.
// [RQ11] Writing the holding buffer with transmitter on starts a transfer.
// [RQ12] Single-word receive enable is ignored in slave operation.
// [RQ13] Continuous receive armed before sleep still takes a whole word.
// [RQ14] A finished word moves into the receive FIFO and may wake the chip.
// [RQ15] Receive ready flag sets on completion; interrupt if enabled.
// [RQ16] Software arms continuous receive after optional interrupt and ninth bit.
// [RQ17] Ninth-bit reception captures one extra bit per word.
// [RQ18] Software reads receive status before the FIFO data byte.
// [RQ19] Clearing continuous receive clears the overrun flag.
// [RQ20] Writing 0x90 to receive status/control enables port and reception.
// [RQ21] Data pin is sampled on the falling shift clock edge.
// [RQ22] Full two-deep FIFO at a third word end sets overrun, drops word.
// [RQ23] While overrun is set, no word enters the FIFO.
// [RQ24] Reading FIFO data presents the next word's ninth bit.
// [RQ25] Transmit data changes on the rising shift clock edge.
// [RQ26] Shift clock is synchronised into the core clock logic.
module usart_sync_slave #(
    parameter int RX_DEPTH = 2
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`APB_ADDR_W-1:0] paddr,
    input  wire logic [`APB_DATA_W-1:0] pwdata,
    output var  logic [`APB_DATA_W-1:0] prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Serial pins
    input  wire logic                   shared_clock_pin_in,
    input  wire logic                   shared_data_pin_in,
    output logic                        shared_data_pin_out,
    output logic                        shared_data_pin_oe,
    // Interrupt requests
    output logic                        tx_irq,
    output logic                        rx_irq,
    output logic                        wake_req
);

    localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW+1)'(RX_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]                       tx_control_status_q;
    logic [7:0]                       rx_control_q;
    logic [7:0]                       tx_holding_data_q;
    logic                             tx_holding_full_q;
    logic [7:0]                       baud_divisor_q;
    logic [1:0]                       irq_enable_q;
    logic [`APB_DATA_W-1:0]           prdata_q;

    logic                             ck_s1_q;
    logic                             ck_s2_q;
    logic                             ck_s3_q;
    logic                             dt_s1_q;
    logic                             dt_s2_q;

    usart_slave_pkg::tx_state_e       tx_state_q;
    logic [8:0]                       tx_shift_register_q;
    logic [3:0]                       tx_left_q;
    logic                             dt_out_q;

    logic [8:0]                       rx_shift_register_q;
    logic [3:0]                       rx_count_q;
    logic                             overrun_error_flag_q;
    usart_slave_pkg::rx_entry_s       fifo_mem [RX_DEPTH];
    logic [PW-1:0]                    wr_ptr_q;
    logic [PW-1:0]                    rd_ptr_q;
    logic [PW:0]                      fifo_count_q;

    logic                             slave_on;
    logic                             tx_on;
    logic                             rx_on;
    logic                             ck_rise;
    logic                             ck_fall;
    logic                             apb_setup;
    logic                             apb_write;
    logic                             apb_read;
    logic                             addr_hit;
    logic                             tx_load;
    logic                             shift_empty_status;
    logic                             tx_buffer_empty_flag;
    logic                             rx_ready_flag;
    logic [8:0]                       rx_next;
    logic [3:0]                       rx_need;
    logic                             rx_done;
    logic                             fifo_full;
    logic                             fifo_push;
    logic                             fifo_pop;
    usart_slave_pkg::rx_entry_s       rx_entry;
    usart_slave_pkg::rx_entry_s       fifo_head;
    logic [7:0]                       rx_control_status;
    logic [`APB_DATA_W-1:0]           rd_value;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    // Slave only when clocked mode is on and clock source select is clear
    assign slave_on = rx_control_q[`RXC_PORT_ON] & tx_control_status_q[`TXC_SYNC_MODE]
                    & ~tx_control_status_q[`TXC_CLOCK_SOURCE];    // see [RQ2]
    // Single-word enable plays no part here
    assign rx_on    = slave_on & rx_control_q[`RXC_CONT_ENABLE];  // see [RQ12]
    // Receive takes the data pin over from transmit, as in master mode
    assign tx_on    = slave_on & tx_control_status_q[`TXC_TRANSMITTER_ON]
                    & ~rx_control_q[`RXC_CONT_ENABLE];            // see [RQ8]

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and shift clock edges

    // Two flops before use; the clock pin is never driven here
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            dt_s1_q <= 1'b0;
            dt_s2_q <= 1'b0;
        end else begin
            ck_s1_q <= shared_clock_pin_in;                       // see [RQ1]
            ck_s2_q <= ck_s1_q;                                   // see [RQ26]
            ck_s3_q <= ck_s2_q;
            dt_s1_q <= shared_data_pin_in;
            dt_s2_q <= dt_s1_q;
        end
    end

    // No sleep gating anywhere: shifting runs on external edges alone
    assign ck_rise = ck_s2_q & ~ck_s3_q;                          // see [RQ3]
    assign ck_fall = ~ck_s2_q & ck_s3_q;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite;
    assign apb_read  = psel & penable & ~pwrite;

    always_comb begin
        case (paddr)
            `OFS_RX_CONTROL,
            `OFS_TX_HOLDING,
            `OFS_TX_CONTROL,
            `OFS_BAUD_DIVISOR,
            `OFS_RX_FIFO,
            `OFS_IRQ_CONTROL: addr_hit = 1'b1;
            default:          addr_hit = 1'b0;
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tx_control_status_q <= `TXC_RESET;
            baud_divisor_q      <= `BAUD_RESET;
            irq_enable_q        <= 2'h0;
        end else if (apb_write) begin
            if (paddr == `OFS_TX_CONTROL) begin
                tx_control_status_q <= pwdata[7:0] & `TXC_WRITE_MASK;
            end
            // Kept for software only; slave mode never divides
            if (paddr == `OFS_BAUD_DIVISOR) begin
                baud_divisor_q <= pwdata[7:0];
            end
            if (paddr == `OFS_IRQ_CONTROL) begin
                irq_enable_q <= pwdata[1:0];
            end
        end
    end

    // 0x90 lands as port on plus continuous receive
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_control_q <= `RXC_RESET;
        end else if (apb_write && paddr == `OFS_RX_CONTROL) begin
            rx_control_q <= pwdata[7:0] & `RXC_WRITE_MASK;        // see [RQ20]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit holding buffer

    assign tx_load = tx_on & tx_holding_full_q & (tx_state_q == usart_slave_pkg::TX_IDLE);

    // A write in the load cycle wins: the old word goes, the new one waits
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tx_holding_data_q <= `TXH_RESET;
            tx_holding_full_q <= 1'b0;
        end else if (apb_write && paddr == `OFS_TX_HOLDING) begin
            tx_holding_data_q <= pwdata[7:0];
            tx_holding_full_q <= 1'b1;                            // see [RQ5]
        end else if (tx_load) begin
            tx_holding_full_q <= 1'b0;                            // see [RQ6]
        end
    end

    assign tx_buffer_empty_flag = ~tx_holding_full_q;
    assign shift_empty_status   = (tx_state_q == usart_slave_pkg::TX_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Transmit shifter

    // Clearing the transmitter aborts the word in flight
    always_ff @(posedge core_clk) begin
        if (!resetn || !tx_on) begin
            tx_state_q          <= usart_slave_pkg::TX_IDLE;
            tx_shift_register_q <= 9'h000;
            tx_left_q           <= 4'h0;
            dt_out_q            <= 1'b0;
        end else begin
            case (tx_state_q)
                usart_slave_pkg::TX_IDLE: begin
                    // Ninth bit is taken as it stands at load time
                    if (tx_holding_full_q) begin
                        tx_shift_register_q <= {tx_control_status_q[`TXC_NINTH_VALUE],
                                                tx_holding_data_q};       // see [RQ4]
                        tx_left_q  <= tx_control_status_q[`TXC_NINTH_ENABLE] ?
                                      `WORD_BITS_9 : `WORD_BITS_8;        // see [RQ11]
                        tx_state_q <= usart_slave_pkg::TX_SHIFT;
                    end
                end
                usart_slave_pkg::TX_SHIFT: begin
                    if (ck_rise) begin
                        dt_out_q            <= tx_shift_register_q[0];    // see [RQ25]
                        tx_shift_register_q <= {1'b0, tx_shift_register_q[8:1]};
                        tx_left_q           <= tx_left_q - 4'h1;
                        if (tx_left_q == 4'h1) begin
                            tx_state_q <= usart_slave_pkg::TX_LAST;
                        end
                    end
                end
                usart_slave_pkg::TX_LAST: begin
                    // Last bit held until the master has sampled it
                    if (ck_fall) begin
                        tx_state_q <= usart_slave_pkg::TX_IDLE;           // see [RQ6]
                    end
                end
                default: begin
                    tx_state_q <= usart_slave_pkg::TX_IDLE;
                end
            endcase
        end
    end

    assign shared_data_pin_out = dt_out_q;
    assign shared_data_pin_oe  = tx_on;

    ////////////////////////////////////////////////////////////////////////
    // Receive shifter

    assign rx_next = {dt_s2_q, rx_shift_register_q[8:1]};
    assign rx_need = rx_control_q[`RXC_NINTH_ENABLE] ? `WORD_BITS_9 : `WORD_BITS_8;  // see [RQ17]
    assign rx_done = rx_on & ck_fall & (rx_count_q == rx_need - 4'h1);

    // Eight-bit words sit in the top of the shifter
    always_comb begin
        if (rx_control_q[`RXC_NINTH_ENABLE]) begin
            rx_entry = {rx_next[8], rx_next[7:0]};
        end else begin
            rx_entry = {1'b0, rx_next[8:1]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn || !rx_on) begin
            rx_shift_register_q <= 9'h000;
            rx_count_q          <= 4'h0;
        end else if (ck_fall) begin
            rx_shift_register_q <= rx_next;                       // see [RQ21]
            rx_count_q          <= rx_done ? 4'h0 : rx_count_q + 4'h1;  // see [RQ13]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive FIFO and overrun

    assign fifo_full = (fifo_count_q == DEPTH_C);
    assign fifo_push = rx_done & ~overrun_error_flag_q & ~fifo_full;  // see [RQ23]
    assign fifo_pop  = apb_read & (paddr == `OFS_RX_FIFO) & (fifo_count_q != '0);

    // Set wins over clear cannot arise: setting needs reception enabled
    always_ff @(posedge core_clk) begin
        if (!resetn || !rx_on) begin
            overrun_error_flag_q <= 1'b0;                         // see [RQ19]
        end else if (rx_done && fifo_full) begin
            overrun_error_flag_q <= 1'b1;                         // see [RQ22]
        end
    end

    for (genvar i = 0; i < RX_DEPTH; i++) begin : g_entry
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                fifo_mem[i] <= '0;
            end else if (fifo_push && wr_ptr_q == PW'(i)) begin
                fifo_mem[i] <= rx_entry;                          // see [RQ14]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wr_ptr_q     <= '0;
            rd_ptr_q     <= '0;
            fifo_count_q <= '0;
        end else begin
            if (fifo_push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(RX_DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
            end
            if (fifo_pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(RX_DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
            end
            case ({fifo_push, fifo_pop})
                2'b10:   fifo_count_q <= fifo_count_q + (PW+1)'(1);
                2'b01:   fifo_count_q <= fifo_count_q - (PW+1)'(1);
                default: fifo_count_q <= fifo_count_q;
            endcase
        end
    end

    // Ninth bit shown always belongs to the word at the head
    assign fifo_head     = (fifo_count_q != '0) ? fifo_mem[rd_ptr_q] : '0;  // see [RQ24]
    assign rx_ready_flag = (fifo_count_q != '0);                 // see [RQ15]

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // No framing in clocked mode, so that flag reads zero
    always_comb begin
        rx_control_status                     = rx_control_q;
        rx_control_status[`RXC_FRAMING_ERROR] = 1'b0;
        rx_control_status[`RXC_OVERRUN]       = overrun_error_flag_q;
        rx_control_status[`RXC_NINTH_VALUE]   = fifo_head.ninth;
    end

    always_comb begin
        rd_value = '0;
        case (paddr)
            `OFS_RX_CONTROL:   rd_value[7:0] = rx_control_status;
            `OFS_TX_HOLDING:   rd_value[7:0] = tx_holding_data_q;
            `OFS_TX_CONTROL: begin
                rd_value[7:0]            = tx_control_status_q;
                rd_value[`TXC_SHIFT_EMPTY] = shift_empty_status;
            end
            `OFS_BAUD_DIVISOR: rd_value[7:0] = baud_divisor_q;
            `OFS_RX_FIFO:      rd_value[7:0] = fifo_head.data;
            `OFS_IRQ_CONTROL: begin
                rd_value[1:0]          = irq_enable_q;
                rd_value[`IRQ_TX_FLAG] = tx_buffer_empty_flag;
                rd_value[`IRQ_RX_FLAG] = rx_ready_flag;
            end
            default:           rd_value = '0;
        endcase
    end

    // Captured in setup so the popping access still returns the old head
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prdata_q <= '0;
        end else if (apb_setup) begin
            prdata_q <= rd_value;
        end
    end

    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests

    assign tx_irq   = tx_buffer_empty_flag & irq_enable_q[`IRQ_TX_ENABLE];  // see [RQ7]
    assign rx_irq   = rx_ready_flag & irq_enable_q[`IRQ_RX_ENABLE];         // see [RQ14]
    assign wake_req = tx_irq | rx_irq;

endmodule
`default_nettype wire

// *** test/sync_master_model.sv ***
// Behavioural far master clocking words in and out of the slave port
`timescale 1ns/1ps
`default_nettype none
module sync_master_model (
    // Device side of the data pin
    input  wire logic dev_out,
    input  wire logic dev_oe,
    // Pins seen by the device
    output logic      sck,
    output logic      line
);
////////////////////////////////////////
    logic drv_en;
    logic drv_val;
    logic last;
    // Released line shows the inverse of its last level, so stale data cannot pass
    assign line = dev_oe ? dev_out : (drv_en ? drv_val : ~last);
    initial begin
        sck = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b0;
        last = 1'b0;
    end
    // Clock idles low outside frames
    task automatic frame(input int nb, input logic [8:0] tx, input logic drive, input real half,
                         output logic [8:0] rx);
        rx = 9'h000;
        for (int i = 0; i < nb; i++) begin
            sck = 1'b1;
            drv_en = drive;
            drv_val = tx[i];
            #half;
            sck = 1'b0;
            rx[i] = line;
            #half;
        end
        last = line;
        drv_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** test/tb_usart_sync_slave.sv ***
// Self-checking bench for the clocked slave serial port
`timescale 1ns/1ps
`default_nettype none
`include "usart_slave_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_usart_sync_slave;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [8:0]  got;
    logic        pready, pslverr, sck, line, dout, doe, tx_irq, rx_irq, wake_req, err;
    int          n_fail = 0;
    int          cmp_count = 0;
    always #4 core_clk = ~core_clk;
    usart_sync_slave #(.RX_DEPTH(2)) DUT (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shared_clock_pin_in(sck), .shared_data_pin_in(line), .shared_data_pin_out(dout),
        .shared_data_pin_oe(doe), .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_req(wake_req));
    sync_master_model MDL (.dev_out(dout), .dev_oe(doe), .sck(sck), .line(line));
////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd, {24'h000000, e})
    endtask
    // Master frame, then room for the two-flop pin delay to settle
    task automatic fr(input int nb, input logic [8:0] tx, input logic dr, input real half);
        MDL.frame(nb, tx, dr, half, got);
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
    endtask
////////////////////////////////////////
    task automatic t_reset();
        logic [11:0] a [6] = '{`OFS_RX_CONTROL, `OFS_TX_HOLDING, `OFS_TX_CONTROL, `OFS_BAUD_DIVISOR,
                               `OFS_RX_FIFO, `OFS_IRQ_CONTROL};
        logic [7:0]  v [6] = '{`RXC_RESET, `TXH_RESET, `TXC_RESET, `BAUD_RESET, 8'h00, 8'h10};
        for (int i = 0; i < 6; i++) rchk(a[i], v[i]);
        apb(1'b1, `OFS_RX_FIFO, 8'hAA);
        rchk(`OFS_RX_FIFO, 8'h00);
        apb(1'b1, `OFS_BAUD_DIVISOR, 8'h5C);
        rchk(`OFS_BAUD_DIVISOR, 8'h5C);
        apb(1'b0, 12'h020, 8'h00);
        `CHK({err, rd}, 33'h100000000)
    endtask
    task automatic t_tx();
        apb(1'b1, `OFS_RX_CONTROL, 8'h80);
        apb(1'b1, `OFS_TX_CONTROL, 8'h30);
        @(negedge core_clk);
        `CHK(doe, 1'b1)
        apb(1'b1, `OFS_IRQ_CONTROL, 8'h01);
        apb(1'b1, `OFS_TX_HOLDING, 8'hA5);
        apb(1'b1, `OFS_TX_HOLDING, 8'h3C);
        rchk(`OFS_IRQ_CONTROL, 8'h01);
        fr(8, 9'h000, 1'b0, 62.5);
        `CHK(got, 9'h0A5)
        rchk(`OFS_IRQ_CONTROL, 8'h11);
        `CHK(wake_req, 1'b1)
        fr(8, 9'h000, 1'b0, 62.5);
        `CHK(got, 9'h03C)
        apb(1'b1, `OFS_TX_CONTROL, 8'h71);
        apb(1'b1, `OFS_TX_HOLDING, 8'h5A);
        fr(9, 9'h000, 1'b0, 62.5);
        `CHK(got, 9'h15A)
        apb(1'b1, `OFS_TX_CONTROL, 8'h10);
        @(negedge core_clk);
        `CHK(doe, 1'b0)
    endtask
    task automatic t_rx();
        apb(1'b1, `OFS_IRQ_CONTROL, 8'h02);
        apb(1'b1, `OFS_RX_CONTROL, 8'h90);
        rchk(`OFS_RX_CONTROL, 8'h90);
        fr(8, 9'h0C3, 1'b1, 62.5);
        `CHK(rx_irq, 1'b1)
        fr(8, 9'h05A, 1'b1, 62.5);
        fr(8, 9'h0FF, 1'b1, 62.5);
        rchk(`OFS_RX_CONTROL, 8'h92);
        rchk(`OFS_RX_FIFO, 8'hC3);
        rchk(`OFS_RX_FIFO, 8'h5A);
        fr(8, 9'h077, 1'b1, 62.5);
        `CHK(rx_irq, 1'b0)
        apb(1'b1, `OFS_RX_CONTROL, 8'h80);
        rchk(`OFS_RX_CONTROL, 8'h80);
        apb(1'b1, `OFS_RX_CONTROL, 8'hF0);
        fr(9, 9'h111, 1'b1, 62.5);
        fr(9, 9'h022, 1'b1, 62.5);
        rchk(`OFS_RX_CONTROL, 8'hF1);
        rchk(`OFS_RX_FIFO, 8'h11);
        rchk(`OFS_RX_CONTROL, 8'hF0);
        rchk(`OFS_RX_FIFO, 8'h22);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        wrap_up();
    end
endmodule
`default_nettype wire

// *** test/usart_sync_slave_checker.sv ***
// Port assertions for the clocked slave serial port
`timescale 1ns/1ps
`default_nettype none
module usart_sync_slave_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and requests
    input wire logic        shared_clock_pin_in,
    input wire logic        shared_data_pin_out,
    input wire logic        shared_data_pin_oe,
    input wire logic        tx_irq,
    input wire logic        rx_irq,
    input wire logic        wake_req
);
////////////////////////////////////////
    logic       ck_q;
    logic [3:0] quiet_q;
    // Cycles since a pin edge or bus access; pin is async, so bounds carry slack
    always_ff @(posedge core_clk) begin
        ck_q <= shared_clock_pin_in;
        if (!resetn || ck_q != shared_clock_pin_in || (psel && penable)) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_xfer;
        psel && !penable ##1 psel && penable;
    endsequence
    AST_ZERO_WAIT: assert property (s_xfer |-> pready) else $error("no ready");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable) else $error("stray error");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 12'h014 ##1 psel && penable |-> pslverr)
        else $error("no error");
    AST_WAKE: assert property (wake_req == (tx_irq || rx_irq)) else $error("wake wrong");
    AST_OE_CAUSE: assert property ($changed(shared_data_pin_oe) |-> $past(psel && penable && pwrite))
        else $error("enable moved");
    AST_RX_DROP: assert property ($fell(rx_irq) |-> $past(psel && penable)) else $error("rx drop");
    AST_TX_DROP: assert property ($fell(tx_irq) |-> $past(psel && penable && pwrite))
        else $error("tx drop");
    AST_TX_STEP: assert property ($changed(shared_data_pin_out) && shared_data_pin_oe |-> quiet_q <= 4'hA)
        else $error("bit moved late");
    AST_RX_RISE: assert property ($rose(rx_irq) |-> quiet_q <= 4'hA) else $error("rx late");
endmodule
bind usart_sync_slave usart_sync_slave_checker u_chk (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .shared_clock_pin_in(shared_clock_pin_in),
    .shared_data_pin_out(shared_data_pin_out), .shared_data_pin_oe(shared_data_pin_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_req(wake_req));
`default_nettype wire
